/* fsp_pkg.sv */
package fsp_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register map, byte addresses on APB
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // Bit positions in the control and status register
   localparam int BIT_SIGNATURE_READ_BIT = 5;
   localparam int BIT_CLEAR = 4;
   localparam int BIT_FUSE = 3;
   localparam int BIT_PGWR = 2;
   localparam int BIT_PGER = 1;
   localparam int BIT_EN = 0;

   // Legal command patterns in the low six bits
   localparam logic [5:0] CMD_FILL = 6'h01;
   localparam logic [5:0] CMD_ERASE = 6'h03;
   localparam logic [5:0] CMD_WRITE = 6'h05;
   localparam logic [5:0] CMD_FUSE = 6'h09;
   localparam logic [5:0] CMD_CLEAR = 6'h11;
   localparam logic [5:0] CMD_SIG = 6'h21;

   ////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam logic [2:0] WIN_SPM = 3'h4;
   localparam logic [2:0] WIN_LPM = 3'h3;
   localparam int CLK_PERIOD_NS = 8;
   localparam int OP_TIME_MIN_NS = 3700000;
   localparam int OP_TIME_MAX_NS = 4500000;
   localparam int OP_CYCLES_MIN = (OP_TIME_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OP_CYCLES_MAX = OP_TIME_MAX_NS / CLK_PERIOD_NS;

   ////////////////////////////////////////////////////////////////////////////
   // Fuse and lock addressing
   localparam logic [15:0] Z_FUSE_LOW = 16'h0000;
   localparam logic [15:0] Z_LOCK = 16'h0001;
   localparam logic [15:0] Z_FUSE_EXT = 16'h0002;
   localparam logic [15:0] Z_FUSE_HIGH = 16'h0003;
   localparam int SIG_BYTES = 6;
   localparam logic [15:0] ERASED_WORD = 16'hFFFF;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ARMED = 2'b01,
      ST_OP = 2'b10
   } fsp_state_t;

   // Programmed state of each cell, high means programmed
   typedef struct packed {
      logic [1:0] lock_prog;
      logic [7:0] ext_prog;
      logic [7:0] high_prog;
      logic [7:0] low_prog;
   } fsp_fuse_t;

   typedef struct packed {
      logic spm;
      logic lpm;
      logic [15:0] z;
      logic [15:0] r1r0;
   } fsp_core_req_t;

endpackage : fsp_pkg

/* fsp_countdown.sv */
`timescale 1ns/100ps
module fsp_countdown
   import fsp_pkg::*;
#(
   parameter int W = 3
)(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Control
   input wire logic load,
   input wire logic [W-1:0] load_value,
   // Status
   output logic [W-1:0] count,
   output logic busy
);

   if (W < 1)
   begin : g_bad_width
      $error("fsp_countdown: width must be at least one");
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         count <= '0;
      else if (load)
         count <= load_value;
      else if (count != '0)
         count <= count - W'(1);
   end

   assign busy = (count != '0);

endmodule : fsp_countdown

/* fsp_self_program.sv */
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
// Function
// - Erase runs only after pattern 03 then a store-program within four cycles.
// - Erase uses only the page field of Z.
// - Buffer load needs pattern 01, data R1:R0, store-program within four cycles.
// - Buffer word is selected by the word-in-page field of Z.
// - Buffer empties after page write, on buffer-clear command and on reset.
// - An EEPROM write during page loading discards the buffer.
// - Page write runs after pattern 05 then store-program within four cycles.
// - The core is halted for the whole erase or write.
// - Bits 7 and 6 are reserved and read zero.
// - Signature mode: load within three cycles returns a row byte; store does nothing.
// - Buffer-clear command during filling drops all loaded data.
// - Fuse mode: load within three cycles returns lock or fuse byte.
// - Write and erase bits clear at completion or after four idle cycles.
// - Plain enable: store writes R1:R0 at Z word, Z bit 0 ignored.
// - Enable clears after store or timeout, held during erase or write.
// - Writes with an illegal low-six-bit pattern have no effect.
// - EEPROM write blocks all programming and fuse or lock reads.
// - Z 0001 reads lock bits, 0000 fuse low, 0003 fuse high.
// - Z 0002 reads the extended fuse byte.
// - Fuse mode bits clear after the read or the timeouts.
// - Programmed bits read zero, unprogrammed bits read one.
// - Signature bits clear after the read or three idle cycles.
// - Erase or write lasts between 3.7 ms and 4.5 ms; the code runs OP_CYCLES cycles, 1 up to OP_CYCLES_MAX.
module fsp_self_program
   import fsp_pkg::*;
#(
   parameter int PAGE_WORDS = 64,
   parameter int OP_CYCLES = OP_CYCLES_MIN
)(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Core instruction side
   input wire fsp_core_req_t core_req,
   output logic core_halt,
   output logic lpm_hit,
   output logic [7:0] lpm_data,
   // EEPROM controller
   input wire logic eeprom_write_busy_flag,
   // Fuse cells and signature row
   input wire fsp_fuse_t fuse_cells,
   input wire logic [8*SIG_BYTES-1:0] sig_row,
   // Flash array side
   output logic flash_busy,
   output logic flash_erase_start,
   output logic flash_write_start,
   output logic [14-$clog2(PAGE_WORDS):0] flash_page,
   input wire logic [$clog2(PAGE_WORDS)-1:0] arr_rd_idx,
   output logic [15:0] arr_rd_data
);

   localparam int WB = $clog2(PAGE_WORDS);
   localparam int PW = 15 - WB;
   localparam int OW = $clog2(OP_CYCLES + 1);

   if (PAGE_WORDS < 2 || (PAGE_WORDS & (PAGE_WORDS - 1)) != 0 || PAGE_WORDS > 8192
       || OP_CYCLES < 1 || OP_CYCLES > OP_CYCLES_MAX)
   begin : g_bad_param
      $error("fsp_self_program: page size or operation length not supported");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   fsp_state_t state;
   logic [5:0] ctrl;
   logic [15:0] page_buf [PAGE_WORDS];
   logic [PAGE_WORDS-1:0] loaded;
   logic op_is_write;
   logic win_load;
   logic [2:0] win_cnt;
   logic win_busy;
   logic op_load;
   logic [OW-1:0] op_cnt;
   logic op_busy;
   logic bus_hit;
   logic bus_wr;
   logic cmd_legal;
   logic cmd_accept;
   logic win_lpm_ok;
   logic spm_go;
   logic lpm_go;
   logic fuse_blocked;
   logic armed_timeout;
   logic op_finish;
   logic buf_clear;
   logic [WB-1:0] word_idx;
   logic [7:0] next_lpm_data;

   ////////////////////////////////////////////////////////////////////////////
   // APB slave, zero wait states
   assign bus_hit = (paddr == ADDR_CTRL);
   assign bus_wr = psel && penable && pwrite && bus_hit && pstrb[0];
   assign pready = 1'b1;
   assign pslverr = psel && penable && !bus_hit;

   // Read data is captured in the setup phase so the bus sees a flop output
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         prdata <= 32'h0000_0000;
      else if (psel && !penable)
         prdata <= bus_hit ? {24'h00_0000, 2'b00, ctrl} : 32'h0000_0000;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Command decode
   always_comb
   begin
      case (pwdata[5:0])
         CMD_FILL, CMD_ERASE, CMD_WRITE, CMD_FUSE, CMD_CLEAR, CMD_SIG:
            cmd_legal = 1'b1;
         default:
            cmd_legal = 1'b0;
      endcase
   end

   // A command is only taken when nothing is pending and no EEPROM write runs
   assign cmd_accept = bus_wr && cmd_legal && (state == ST_IDLE)
                       && !eeprom_write_busy_flag;

   ////////////////////////////////////////////////////////////////////////////
   // Instruction windows
   // Count 4..1 after the command: store allowed in all four, load in the first three
   fsp_countdown #(
      .W(3)
   ) u_window (
      .clk_sys(clk_sys),
      .rst(rst),
      .load(win_load),
      .load_value(WIN_SPM),
      .count(win_cnt),
      .busy(win_busy)
   );

   assign win_load = cmd_accept;
   assign win_lpm_ok = (win_cnt > (WIN_SPM - WIN_LPM));
   assign fuse_blocked = eeprom_write_busy_flag && ctrl[BIT_FUSE];
   assign spm_go = (state == ST_ARMED) && core_req.spm && win_busy
                   && !eeprom_write_busy_flag;
   assign lpm_go = (state == ST_ARMED) && core_req.lpm && win_lpm_ok
                   && (ctrl[BIT_FUSE] || ctrl[BIT_SIGNATURE_READ_BIT]) && !fuse_blocked;

   // Signature mode lives three cycles, every other mode four
   always_comb
   begin
      // The last legal instruction slot is also the timeout slot, so no dead cycle follows
      if (ctrl[BIT_SIGNATURE_READ_BIT])
         armed_timeout = (win_cnt <= (WIN_SPM - WIN_LPM + 3'h1));
      else
         armed_timeout = (win_cnt <= 3'h1);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Operation timer
   fsp_countdown #(
      .W(OW)
   ) u_op_timer (
      .clk_sys(clk_sys),
      .rst(rst),
      .load(op_load),
      .load_value(OW'(OP_CYCLES)),
      .count(op_cnt),
      .busy(op_busy)
   );

   // Only erase and write reach the timer; the others finish on their own instruction
   assign op_load = spm_go && (ctrl[BIT_PGER] || ctrl[BIT_PGWR]);
   assign op_finish = (state == ST_OP) && (op_cnt == OW'(1));

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer and control bits
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         state <= ST_IDLE;
      else
      begin
         case (state)
            ST_IDLE:
               if (cmd_accept)
                  state <= ST_ARMED;
            ST_ARMED:
               if (op_load)
                  state <= ST_OP;
               else if (lpm_go)
                  state <= ST_IDLE;
               else if (spm_go && !ctrl[BIT_SIGNATURE_READ_BIT] && !ctrl[BIT_FUSE])
                  state <= ST_IDLE;
               else if (armed_timeout)
                  state <= ST_IDLE;
            ST_OP:
               if (op_finish)
                  state <= ST_IDLE;
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   // Control bits mirror the pending command and fall with the sequencer
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         ctrl <= CTRL_RESET[5:0];
      else if (cmd_accept)
         ctrl <= pwdata[5:0];
      else if (state == ST_ARMED && !op_load
               && (lpm_go || armed_timeout
                   || (spm_go && !ctrl[BIT_SIGNATURE_READ_BIT] && !ctrl[BIT_FUSE])))
         ctrl <= 6'h00;
      else if (op_finish)
         ctrl <= 6'h00;
   end

   // Enable and operation bits stay up through the timed operation
   assign core_halt = (state == ST_OP) && op_busy;
   assign flash_busy = (state == ST_OP);

   ////////////////////////////////////////////////////////////////////////////
   // Flash array commands
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         flash_erase_start <= 1'b0;
         flash_write_start <= 1'b0;
      end
      else
      begin
         flash_erase_start <= op_load && ctrl[BIT_PGER];
         flash_write_start <= op_load && ctrl[BIT_PGWR];
      end
   end

   // Only the page field is kept; lower Z bits are dropped
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         flash_page <= '0;
         op_is_write <= 1'b0;
      end
      else if (op_load)
      begin
         flash_page <= core_req.z[15:WB+1];
         op_is_write <= ctrl[BIT_PGWR];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Temporary page buffer
   // Bit 0 of Z selects a byte, so the word index starts at bit 1
   assign word_idx = core_req.z[WB:1];

   always_comb
   begin
      buf_clear = 1'b0;
      if (cmd_accept && pwdata[5:0] == CMD_CLEAR)
         buf_clear = 1'b1;
      if (op_finish && op_is_write)
         buf_clear = 1'b1;
      if (eeprom_write_busy_flag && (loaded != '0))
         buf_clear = 1'b1;
   end

   // Only the valid bits are reset; data words need no reset since they are masked
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         loaded <= '0;
      else if (buf_clear)
         loaded <= '0;
      else if (spm_go && ctrl == CMD_FILL)
         loaded[word_idx] <= 1'b1;
   end

   // A second load to a filled word is dropped rather than merged
   always_ff @(posedge clk_sys)
   begin
      if (spm_go && ctrl == CMD_FILL && !loaded[word_idx] && !buf_clear)
         page_buf[word_idx] <= core_req.r1r0;
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         arr_rd_data <= ERASED_WORD;
      else if (loaded[arr_rd_idx])
         arr_rd_data <= page_buf[arr_rd_idx];
      else
         arr_rd_data <= ERASED_WORD;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Fuse, lock and signature reads
   // Cells report programmed as high, so the byte is inverted on the way out
   always_comb
   begin
      next_lpm_data = ERASED_BYTE;
      if (ctrl[BIT_FUSE])
      begin
         case (core_req.z)
            Z_FUSE_LOW:
               next_lpm_data = ~fuse_cells.low_prog;
            Z_LOCK:
               next_lpm_data = {6'h3F, ~fuse_cells.lock_prog};
            Z_FUSE_EXT:
               next_lpm_data = ~fuse_cells.ext_prog;
            Z_FUSE_HIGH:
               next_lpm_data = ~fuse_cells.high_prog;
            default:
               next_lpm_data = ERASED_BYTE;
         endcase
      end
      else if (core_req.z < 16'(SIG_BYTES))
         next_lpm_data = sig_row[8*core_req.z[2:0] +: 8];
   end

   // Answer lands one cycle after the load instruction
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         lpm_hit <= 1'b0;
         lpm_data <= 8'h00;
      end
      else
      begin
         lpm_hit <= lpm_go;
         if (lpm_go)
            lpm_data <= next_lpm_data;
      end
   end

endmodule : fsp_self_program

/* fsp_self_program_sva.sv */
`timescale 1ns/100ps
module fsp_self_program_sva
   import fsp_pkg::*;
#(
   parameter int OP_CYCLES = OP_CYCLES_MIN
)(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   // Core and flash side
   input wire fsp_core_req_t core_req,
   input wire logic core_halt,
   input wire logic lpm_hit,
   input wire logic eeprom_write_busy_flag,
   input wire logic flash_busy,
   input wire logic flash_erase_start,
   input wire logic flash_write_start
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////////////////////
   // Length of the last busy stretch, too long for a repetition
   int unsigned busy_cycles;
   always_ff @(posedge clk_sys)
   begin
      if (rst || !flash_busy)
         busy_cycles <= 0;
      else
         busy_cycles <= busy_cycles + 1;
   end

   ////////////////////////////////////////////////////////////////////////////
   a_rsv_bits_zero: assert property (psel && penable && !pwrite && paddr == 12'h000
      |-> prdata[7:6] == 2'h0) else $error("reserved control bits read nonzero");
   a_halt_during_op: assert property (flash_busy |-> core_halt)
      else $error("core not halted during flash operation");
   a_start_halts: assert property ((flash_erase_start || flash_write_start)
      |-> core_halt ##1 core_halt) else $error("start without halt");
   a_op_length: assert property ($fell(flash_busy) |-> busy_cycles == OP_CYCLES)
      else $error("flash operation length wrong");
   a_erase_cause: assert property (flash_erase_start
      |-> $past(core_req.spm) && !$past(eeprom_write_busy_flag)) else $error("stray erase");
   a_write_cause: assert property (flash_write_start
      |-> $past(core_req.spm) && !$past(eeprom_write_busy_flag)) else $error("stray write");
   a_lpm_cause: assert property (lpm_hit |-> $past(core_req.lpm))
      else $error("answer without load instruction");
   a_ee_blocks: assert property (eeprom_write_busy_flag && core_req.spm
      |=> !flash_erase_start && !flash_write_start) else $error("programming while eeprom busy");
endmodule : fsp_self_program_sva

bind fsp_self_program fsp_self_program_sva #(.OP_CYCLES(OP_CYCLES)) u_sva (.clk_sys, .rst,
   .psel, .penable, .pwrite, .paddr, .prdata, .core_req, .core_halt, .lpm_hit,
   .eeprom_write_busy_flag, .flash_busy, .flash_erase_start, .flash_write_start);

/* fsp_core_model.sv */
`timescale 1ns/100ps
module fsp_core_model
   import fsp_pkg::*;
(
   // Clock
   input wire logic clk_sys,
   // Device side
   input wire logic core_halt,
   output fsp_core_req_t core_req
);
   initial core_req = '0;

   // One instruction; a halted core issues nothing, and the operand
   // lines are inverted afterwards so stale values never look valid
   task automatic issue(input logic is_spm, input logic [15:0] z, input logic [15:0] d);
      for (int i = 0; i < 100 && core_halt === 1'b1; i++)
         @(posedge clk_sys);
      if (core_halt === 1'b1)
         tb.fail_wait();
      core_req.spm <= is_spm;
      core_req.lpm <= !is_spm;
      core_req.z <= z;
      core_req.r1r0 <= d;
      @(posedge clk_sys);
      core_req <= '{spm: 1'b0, lpm: 1'b0, z: ~z, r1r0: ~d};
   endtask : issue
endmodule : fsp_core_model

/* tb.sv */
`timescale 1ns/100ps
`define CHK(g, e) chk(32'(g), 32'(e))
module tb
   import fsp_pkg::*;
;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   fsp_core_req_t core_req;
   logic core_halt;
   logic lpm_hit;
   logic [7:0] lpm_data;
   logic ee_busy = 1'b0;
   fsp_fuse_t fuse_cells = '0;
   logic [47:0] sig_row = '0;
   logic flash_busy;
   logic [1:0] fl_start;
   logic [8:0] flash_page;
   logic [5:0] rd_idx = 6'h00;
   logic [15:0] arr_rd_data;
   logic [15:0] mbuf [64];
   logic [31:0] rd;
   logic slv;
   int mismatches = 0;
   int check_count = 0;

   fsp_self_program #(.OP_CYCLES(20)) u_dut (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr, .core_req, .core_halt, .lpm_hit,
      .lpm_data, .eeprom_write_busy_flag(ee_busy), .fuse_cells, .sig_row, .flash_busy,
      .flash_erase_start(fl_start[0]), .flash_write_start(fl_start[1]), .flash_page,
      .arr_rd_idx(rd_idx), .arr_rd_data);
   fsp_core_model u_core (.clk_sys, .core_halt, .core_req);

   initial
      forever #4 clk_sys = ~clk_sys;

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e)
      begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : tally_and_finish

   task automatic fail_wait();
      mismatches++;
      tally_and_finish();
   endtask : fail_wait

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int i;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      for (i = 0; i < 20; i++)
      begin
         @(posedge clk_sys);
         if (pready === 1'b1)
            break;
      end
      if (i == 20)
         fail_wait();
      rd = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // One idle edge so a following call never reassigns psel in this time step
      @(posedge clk_sys);
   endtask : apb

   task automatic wctl(input logic [7:0] v);
      apb(1'b1, ADDR_CTRL, {24'h0, v});
   endtask : wctl

   task automatic expect_ctl(input logic [7:0] e);
      apb(1'b0, ADDR_CTRL, 32'h0);
      `CHK(rd, e);
   endtask : expect_ctl

   // Empty words read all ones, so loaded data is kept below that value
   task automatic fill(input int w, input logic [15:0] d);
      wctl(8'(CMD_FILL));
      u_core.issue(1'b1, {9'($urandom), 6'(w), 1'b1}, d);
      if (mbuf[w] === 16'hFFFF)
         mbuf[w] = d;
   endtask : fill

   task automatic clr_model();
      foreach (mbuf[i])
         mbuf[i] = 16'hFFFF;
   endtask : clr_model

   task automatic check_buf();
      for (int i = 0; i < 64; i++)
      begin
         rd_idx <= 6'(i);
         repeat (2) @(posedge clk_sys);
         `CHK(arr_rd_data, mbuf[i]);
      end
   endtask : check_buf

   // The answer pulse stands one cycle, so it is looked at mid-cycle
   task automatic expect_lpm(input logic hit, input logic [7:0] e);
      @(negedge clk_sys);
      `CHK(lpm_hit, hit);
      `CHK(lpm_data, e);
      @(posedge clk_sys);
   endtask : expect_lpm

   task automatic wait_idle();
      int i;
      for (i = 0; i < 100 && flash_busy !== 1'b0; i++)
         @(posedge clk_sys);
      if (i == 100)
         fail_wait();
   endtask : wait_idle

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      logic [31:0] r;
      logic [63:0] s;
      logic [7:0] fx [4];
      logic [7:0] bad [4];
      r = $urandom(43);
      s = {$urandom(), $urandom()};
      fuse_cells <= fsp_fuse_t'(r[25:0]);
      sig_row <= s[47:0];
      fx = '{~r[7:0], {6'h3F, ~r[25:24]}, ~r[23:16], ~r[15:8]};
      bad = '{8'h07, 8'h02, 8'h3F, 8'h31};
      clr_model();
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      expect_ctl(CTRL_RESET);
      apb(1'b1, 12'h004, 32'h3);
      `CHK(slv, 1'b1);
      expect_ctl(8'h00);
      for (int k = 0; k < 6; k++)
         fill(k * 13 % 64, 16'($urandom) & 16'h7FFF);
      fill(13, 16'h0123);
      fill(63, 16'h7EEE);
      expect_ctl(8'h00);
      check_buf();
      wctl(8'hC1);
      expect_ctl(8'h01);
      repeat (4) @(posedge clk_sys);
      expect_ctl(8'h00);
      for (int i = 0; i < 4; i++)
      begin
         wctl(bad[i]);
         expect_ctl(8'h00);
      end
      for (int z = 0; z < 4; z++)
      begin
         wctl(8'(CMD_FUSE));
         u_core.issue(1'b0, 16'(z), 16'h0000);
         expect_lpm(1'b1, fx[z]);
         expect_ctl(8'h00);
      end
      wctl(8'(CMD_FUSE));
      ee_busy <= 1'b1;
      u_core.issue(1'b0, 16'h0000, 16'h0000);
      expect_lpm(1'b0, fx[3]);
      wctl(8'(CMD_FILL));
      expect_ctl(8'h00);
      ee_busy <= 1'b0;
      clr_model();
      check_buf();
      for (int z = 0; z < 6; z++)
      begin
         wctl(8'(CMD_SIG));
         u_core.issue(1'b0, 16'(z), 16'h0000);
         expect_lpm(1'b1, s[8*z+:8]);
      end
      expect_ctl(8'h00);
      wctl(8'(CMD_SIG));
      u_core.issue(1'b1, 16'h0002, 16'h0BAD);
      expect_ctl(8'h21);
      repeat (3) @(posedge clk_sys);
      expect_ctl(8'h00);
      fill(7, 16'h1111);
      fill(8, 16'h2222);
      wctl(8'(CMD_CLEAR));
      clr_model();
      check_buf();
      // Erase keeps the buffer so a page can be refilled before writing
      for (int op = 0; op < 2; op++)
      begin
         logic [15:0] z;
         z = {9'($urandom), 7'h00};
         fill(3, 16'h3333);
         wctl(op ? 8'(CMD_WRITE) : 8'(CMD_ERASE));
         u_core.issue(1'b1, op ? z : (z | 16'h007F), 16'hFFFF);
         // Start pulses stand one cycle, so they are looked at mid-cycle
         @(negedge clk_sys);
         `CHK(fl_start, op ? 2'b10 : 2'b01);
         `CHK(flash_page, z[15:7]);
         `CHK(core_halt, 1'b1);
         @(posedge clk_sys);
         expect_ctl(op ? 8'(CMD_WRITE) : 8'(CMD_ERASE));
         wait_idle();
         expect_ctl(8'h00);
         if (op)
            clr_model();
         check_buf();
      end
      fill(9, 16'h4444);
      rst <= 1'b1;
      @(posedge clk_sys);
      rst <= 1'b0;
      clr_model();
      check_buf();
      tally_and_finish();
   end
endmodule : tb
